/* File: rtl/stroke_pkg.sv */
package stroke_pkg;

  // sample timing
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned SAMPLE_NS = 1000000;
  localparam int unsigned SAMPLE_CYC = SAMPLE_NS / CLK_NS;

  // register byte offsets; config words are indexed by addr[5:2]
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BRAKE = 8'h04;
  localparam logic [7:0] OFS_WINDOW = 8'h08;
  localparam logic [7:0] OFS_JOG_VEL = 8'h0c;
  localparam logic [7:0] OFS_STOP_DIST = 8'h10;
  localparam logic [7:0] OFS_FAULT_VAL = 8'h14;
  localparam logic [7:0] OFS_FAULT_SEL = 8'h18;
  localparam logic [7:0] OFS_FORCE_LO = 8'h1c;
  localparam logic [7:0] OFS_FORCE_HI = 8'h20;
  localparam logic [7:0] OFS_FORCE_SPD = 8'h24;
  localparam logic [7:0] OFS_DB_MIN = 8'h28;
  localparam logic [7:0] OFS_FAULT_VEL = 8'h2c;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_TARGET = 8'h34;
  localparam logic [7:0] OFS_DRIVE = 8'h38;
  localparam int unsigned NUM_CFG = 12;

  // control word fields
  localparam int unsigned CTRL_CURVE = 0;
  localparam int unsigned CTRL_SPD_EXT = 2;
  localparam int unsigned CTRL_FORCE_EN = 3;
  localparam int unsigned CTRL_FORCE_DIR = 4;
  localparam int unsigned CTRL_FAULT_DRV = 5;
  localparam int unsigned CTRL_FAULT_DIR = 6;
  // fault event select fields
  localparam int unsigned FSEL_SENSOR = 0;
  localparam int unsigned FSEL_ENABLE = 1;
  // status word fields
  localparam int unsigned STAT_READY = 0;
  localparam int unsigned STAT_INPOS = 1;
  localparam int unsigned STAT_FAULT = 2;
  localparam int unsigned STAT_STATE = 4;

  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0001;
  localparam logic [15:0] BRAKE_RST = 16'h1000;
  localparam logic [15:0] WINDOW_RST = 16'h0040;
  localparam logic [15:0] JOG_VEL_RST = 16'h1000;
  localparam logic [15:0] STOP_DIST_RST = 16'h0200;
  localparam logic [15:0] FSEL_RST = 16'h0003;
  localparam logic [15:0] FORCE_SPD_RST = 16'h0800;
  localparam logic [15:0] FAULT_VEL_RST = 16'h0800;

  // control law constants
  localparam logic [15:0] OUT_FS = 16'h7fff;
  localparam logic [15:0] DB_TRIG = 16'h0400;
  localparam int unsigned GAIN_Q = 4;
  localparam int unsigned GAIN_FAC_LIN = 1;
  localparam int unsigned GAIN_FAC_THREE = 3;
  localparam int unsigned GAIN_FAC_FIVE = 5;

  typedef enum logic [1:0] {CURVE_LINEAR, ROOT_CURVE_GAIN_THREE, ROOT_CURVE_GAIN_FIVE} curve_t;
  typedef enum {ST_OFF, ST_HOLD, ST_RUN, ST_JOG, ST_FAULT} seq_state_t;

  // magnitude of a signed error, capped at full scale
  function automatic logic [15:0] mag17(input logic signed [16:0] v);
    logic [16:0] m;
    m = v[16] ? 17'(-v) : 17'(v);
    return (m > 17'(OUT_FS)) ? OUT_FS : m[15:0];
  endfunction

  // magnitude and direction to a saturated signed drive value
  function automatic logic signed [15:0] signed_drive(input logic [15:0] m, input logic neg);
    logic [15:0] s;
    s = (m > OUT_FS) ? OUT_FS : m;
    return neg ? -$signed(s) : $signed(s);
  endfunction

  function automatic logic is_cfg(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a < OFS_STATUS);
  endfunction

  function automatic logic [15:0] cfg_reset(input int unsigned i);
    case (i)
      32'(OFS_CTRL[5:2]): return CTRL_RST;
      32'(OFS_BRAKE[5:2]): return BRAKE_RST;
      32'(OFS_WINDOW[5:2]): return WINDOW_RST;
      32'(OFS_JOG_VEL[5:2]): return JOG_VEL_RST;
      32'(OFS_STOP_DIST[5:2]): return STOP_DIST_RST;
      32'(OFS_FAULT_SEL[5:2]): return FSEL_RST;
      32'(OFS_FORCE_SPD[5:2]): return FORCE_SPD_RST;
      32'(OFS_FAULT_VEL[5:2]): return FAULT_VEL_RST;
      default: return 16'h0000;
    endcase
  endfunction

endpackage

/* File: rtl/law_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface law_if;
  logic signed [16:0] err;
  logic [15:0] brake;
  logic [15:0] db_min;
  logic [15:0] vlim;
  logic [1:0] curve;
  logic signed [15:0] u;
  modport ctl (output err, output brake, output db_min, output vlim, output curve, input u);
  modport law (input err, input brake, input db_min, input vlim, input curve, output u);
endinterface
`default_nettype wire

/* File: rtl/sample_ticker.sv */
`timescale 1ns/1ns
`default_nettype none
module sample_ticker #(
  parameter int unsigned CYCLES = stroke_pkg::SAMPLE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // sample strobe
  output logic tick
);
  import stroke_pkg::*;

  logic [23:0] cnt_q;
  logic [23:0] cnt_d;

  // free-running divider, wraps once per sample period
  always_comb
  begin
    cnt_d = (cnt_q == 24'(CYCLES - 1)) ? 24'h000000 : cnt_q + 24'h000001;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_q <= 24'h000000;
    else if (ce)
      cnt_q <= cnt_d;
  end

  assign tick = (cnt_q == 24'(CYCLES - 1));

  tick_single_a: assert property (@(posedge clk) disable iff (!arst_n)
    tick && ce |=> !tick)
    else $error("sample tick lasted more than one enabled cycle");

endmodule // sample_ticker
`default_nettype wire

/* File: rtl/curve_law.sv */
`timescale 1ns/1ns
`default_nettype none
module curve_law (
  // law operands and result
  law_if.law lw
);
  import stroke_pkg::*;

  logic [15:0] mag;
  logic [31:0] bk;
  logic [31:0] ec;
  logic [31:0] u0;
  logic [31:0] fac;
  logic [31:0] fq;
  logic [31:0] u1;
  logic [31:0] u2;

  // braking-distance gain, curve boost near target, then two-slope deadband
  always_comb
  begin
    mag = mag17(lw.err);
    bk = (lw.brake == 16'h0000) ? 32'h00000001 : 32'(lw.brake);
    ec = (32'(mag) >= bk) ? bk : 32'(mag);
    u0 = (ec * 32'(OUT_FS)) / bk; // shorter brake distance, steeper gain
    case (curve_t'(lw.curve))
      ROOT_CURVE_GAIN_THREE: fac = GAIN_FAC_THREE;
      ROOT_CURVE_GAIN_FIVE: fac = GAIN_FAC_FIVE;
      default: fac = GAIN_FAC_LIN;
    endcase
    // boost is full at zero error and falls to one at the brake distance
    fq = (fac << GAIN_Q) - (((fac - 1) << GAIN_Q) * ec) / bk;
    u1 = (u0 * fq) >> GAIN_Q;
    if (u1 > 32'(OUT_FS))
      u1 = 32'(OUT_FS);
    // steep slope below the trigger, offset slope above: no jump at zero
    if (u1 == 32'h0)
      u2 = 32'h0;
    else if (u1 <= 32'(DB_TRIG))
      u2 = (u1 * (32'(DB_TRIG) + 32'(lw.db_min))) / 32'(DB_TRIG);
    else
      u2 = u1 + 32'(lw.db_min);
    if (u2 > 32'(lw.vlim))
      u2 = 32'(lw.vlim); // speed limit
    lw.u = signed_drive((u2 > 32'(OUT_FS)) ? OUT_FS : u2[15:0], lw.err[16]);
  end

endmodule // curve_law
`default_nettype wire

/* File: rtl/stroke_position_sequencer.sv */
// Contract
// - enable rise loads target from measured position
// - ready output shows axis ready to operate
// - jog inputs move axis at jog velocity
// - jog release takes measured position as target
// - start follows analog command position immediately; target takes cmd_pos only from the tick after ST_RUN is entered
// - in-position while within window and started
// - gain rises as braking distance shrinks
// - compare position to target; optional speed limit
// - forced stroke: speed, direction, area configurable
// - failure forces programmed output or end drive
// - selectable events trigger fault output
// - linear curve boosts gain by one
// - default root curve boosts gain three
// - second root curve boosts gain five
// - deadband uses two-slope gain, no step
// - start removal stops within stopping distance
// - in-position drops when error exceeds window
// - enable activation reinitialises and clears errors
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module stroke_position_sequencer #(
  parameter int unsigned TICK_CYCLES = stroke_pkg::SAMPLE_CYC
) (
  // clock, reset, clock enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // digital pins
  input wire logic enable_in,
  input wire logic start_in,
  input wire logic jog_up_in,
  input wire logic jog_down_in,
  // converted analog values, same clock
  input wire logic [15:0] sensor_pos,
  input wire logic [15:0] cmd_pos,
  input wire logic [15:0] cmd_speed,
  input wire logic sensor_fault,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // actuator and status
  output logic signed [15:0] drive_value,
  output logic ready,
  output logic in_position
);
  import stroke_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] sync1_d;
  logic [3:0] sync2_d;
  logic en_s;
  logic start_s;
  logic jog_up_s;
  logic jog_down_s;

  // first stage feeds only the second stage
  always_comb
  begin
    sync1_d = {jog_down_in, jog_up_in, start_in, enable_in};
    sync2_d = sync1_q;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end
    else if (ce)
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  assign {jog_down_s, jog_up_s, start_s, en_s} = sync2_q;

  //////////////////////////////////////////////////////////////////////////////
  // sample tick

  logic tick;
  logic tick_ce;

  sample_ticker #(.CYCLES(TICK_CYCLES)) u_ticker (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .tick(tick)
  );

  assign tick_ce = tick & ce;

  //////////////////////////////////////////////////////////////////////////////
  // register file

  logic [15:0] cfg_q [NUM_CFG];
  logic [15:0] cfg_d [NUM_CFG];
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  seq_state_t state_q;
  logic [15:0] target_q;
  logic signed [15:0] drive_q;
  logic fault_q;
  logic inpos_q;
  logic ready_q;

  // writes land in the indexed word; reads answer one cycle later, else zero
  always_comb
  begin
    cfg_d = cfg_q;
    if (wr && is_cfg(addr))
      cfg_d[addr[5:2]] = wdata[15:0];
    rdata_d = 32'h00000000;
    if (rd)
    begin
      if (is_cfg(addr))
        rdata_d = {16'h0000, cfg_q[addr[5:2]]};
      else if (addr == OFS_STATUS)
      begin
        rdata_d[STAT_READY] = ready_q;
        rdata_d[STAT_INPOS] = inpos_q;
        rdata_d[STAT_FAULT] = fault_q;
        rdata_d[STAT_STATE +: 3] = 3'(state_q);
      end
      else if (addr == OFS_TARGET)
        rdata_d = {16'h0000, target_q};
      else if (addr == OFS_DRIVE)
        rdata_d = {{16{drive_q[15]}}, drive_q};
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < NUM_CFG; i++)
        cfg_q[i] <= cfg_reset(i);
      rdata_q <= 32'h00000000;
    end
    else if (ce)
    begin
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

  // named views of the configuration words
  logic [15:0] ctrl_w;
  logic [15:0] fsel_w;
  logic [15:0] stop_w;
  assign ctrl_w = cfg_q[OFS_CTRL[5:2]];
  assign fsel_w = cfg_q[OFS_FAULT_SEL[5:2]];
  assign stop_w = cfg_q[OFS_STOP_DIST[5:2]];

  //////////////////////////////////////////////////////////////////////////////
  // sequence: state, target and latched fault, all moving on the tick

  seq_state_t state_d;
  logic [15:0] target_d;
  logic fault_d;
  logic en_prev_q;
  logic en_prev_d;
  logic en_rise;
  logic fault_ev;
  logic jog_any;
  logic [16:0] stop_up;
  logic [15:0] stop_tgt;

  assign en_rise = en_s & ~en_prev_q;
  assign fault_ev = sensor_fault & fsel_w[FSEL_SENSOR];
  assign jog_any = jog_up_s | jog_down_s;
  assign stop_up = {1'b0, sensor_pos} + {1'b0, stop_w};

  // stop point one stopping distance ahead of the motion, clamped to stroke ends
  always_comb
  begin
    if (drive_q > 16'sd0)
      stop_tgt = stop_up[16] ? 16'hffff : stop_up[15:0];
    else if (drive_q < 16'sd0)
      stop_tgt = (sensor_pos > stop_w) ? sensor_pos - stop_w : 16'h0000;
    else
      stop_tgt = sensor_pos;
  end

  always_comb
  begin
    state_d = state_q;
    target_d = target_q;
    fault_d = fault_q;
    en_prev_d = en_prev_q;
    if (tick_ce)
    begin
      en_prev_d = en_s;
      if (!en_s)
        state_d = ST_OFF;
      else if (en_rise)
      begin
        target_d = sensor_pos;
        // clear on activation, but a sensor event in the same tick still sets the latch
        fault_d = fault_ev;
        state_d = ST_HOLD;
      end
      else if (fault_q || fault_ev)
      begin
        fault_d = 1'b1;
        state_d = ST_FAULT;
      end
      else
      begin
        case (state_q)
          ST_HOLD:
            if (start_s)
              state_d = ST_RUN;
            else if (jog_any)
              state_d = ST_JOG;
          ST_RUN:
            if (start_s)
              target_d = cmd_pos;
            else
            begin
              target_d = stop_tgt;
              state_d = ST_HOLD;
            end
          ST_JOG:
            if (start_s || !jog_any)
            begin
              target_d = sensor_pos;
              state_d = start_s ? ST_RUN : ST_HOLD;
            end
          default:
          begin
            target_d = sensor_pos;
            state_d = ST_HOLD;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= ST_OFF;
      target_q <= 16'h0000;
      fault_q <= 1'b0;
      en_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      state_q <= state_d;
      target_q <= target_d;
      fault_q <= fault_d;
      en_prev_q <= en_prev_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control law on the target chosen this tick

  law_if lw ();
  logic signed [15:0] law_u;

  assign lw.err = $signed({1'b0, target_d}) - $signed({1'b0, sensor_pos});
  assign lw.brake = cfg_q[OFS_BRAKE[5:2]];
  assign lw.db_min = cfg_q[OFS_DB_MIN[5:2]];
  assign lw.curve = ctrl_w[CTRL_CURVE +: 2];
  assign lw.vlim = ctrl_w[CTRL_SPD_EXT] ? cmd_speed : OUT_FS;
  assign law_u = lw.u;

  curve_law u_law (
    .lw(lw)
  );

  //////////////////////////////////////////////////////////////////////////////
  // outputs: drive value, in-position, ready

  logic signed [15:0] drive_d;
  logic signed [15:0] fault_resp;
  logic inpos_d;
  logic ready_d;
  logic in_force_area;

  // programmed value, or a run toward one end at the programmed velocity
  assign fault_resp = ctrl_w[CTRL_FAULT_DRV] ?
    signed_drive(cfg_q[OFS_FAULT_VEL[5:2]], ~ctrl_w[CTRL_FAULT_DIR]) :
    $signed(cfg_q[OFS_FAULT_VAL[5:2]]);
  assign in_force_area = (sensor_pos >= cfg_q[OFS_FORCE_LO[5:2]]) &&
    (sensor_pos <= cfg_q[OFS_FORCE_HI[5:2]]);

  always_comb
  begin
    drive_d = drive_q;
    inpos_d = inpos_q;
    ready_d = en_s & ~fault_q;
    if (tick_ce)
    begin
      // window check only counts while started
      inpos_d = start_s && (state_d == ST_RUN) &&
        (mag17(lw.err) <= cfg_q[OFS_WINDOW[5:2]]);
      case (state_d)
        ST_OFF:
          drive_d = fsel_w[FSEL_ENABLE] ? fault_resp : 16'sd0;
        ST_FAULT:
          drive_d = fault_resp;
        ST_JOG:
          // both jog pins together cancel rather than pick a winner
          if (jog_up_s && !jog_down_s)
            drive_d = signed_drive(cfg_q[OFS_JOG_VEL[5:2]], 1'b0);
          else if (jog_down_s && !jog_up_s)
            drive_d = signed_drive(cfg_q[OFS_JOG_VEL[5:2]], 1'b1);
          else
            drive_d = 16'sd0;
        default:
          if (ctrl_w[CTRL_FORCE_EN] && in_force_area)
            drive_d = signed_drive(cfg_q[OFS_FORCE_SPD[5:2]], ~ctrl_w[CTRL_FORCE_DIR]);
          else
            drive_d = law_u;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      drive_q <= 16'sd0;
      inpos_q <= 1'b0;
      ready_q <= 1'b0;
    end
    else if (ce)
    begin
      drive_q <= drive_d;
      inpos_q <= inpos_d;
      ready_q <= ready_d;
    end
  end

  assign drive_value = drive_q;
  assign in_position = inpos_q;
  assign ready = ready_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  enable_load_a: assert property (tick_ce && en_s && en_rise |=>
    target_q == $past(sensor_pos) && state_q == ST_HOLD && fault_q == $past(fault_ev))
    else $error("enable rise did not load measured position");

  ready_cause_a: assert property (ready_q |-> $past(en_s) && !$past(fault_q))
    else $error("ready shown without enable or with fault");

  jog_drive_a: assert property (tick_ce && state_d == ST_JOG && jog_up_s && !jog_down_s |=>
    drive_q == signed_drive($past(cfg_q[OFS_JOG_VEL[5:2]]), 1'b0))
    else $error("jog up did not drive at jog velocity");

  jog_release_a: assert property (tick_ce && state_q == ST_JOG && en_s && !en_rise &&
    !fault_q && !fault_ev && !jog_any && !start_s |=> target_q == $past(sensor_pos))
    else $error("jog release did not take measured position");

  run_follow_a: assert property (tick_ce && state_q == ST_RUN && start_s && en_s &&
    !fault_q && !fault_ev |=> target_q == $past(cmd_pos))
    else $error("run did not follow command position");

  inpos_window_a: assert property (tick_ce &&
    mag17(lw.err) > cfg_q[OFS_WINDOW[5:2]] |=> !inpos_q)
    else $error("in-position held outside window");

  inpos_start_a: assert property (inpos_q |-> state_q == ST_RUN)
    else $error("in-position without running");

  fault_out_a: assert property (tick_ce && state_d == ST_FAULT &&
    !ctrl_w[CTRL_FAULT_DRV] |=> drive_q == $signed($past(cfg_q[OFS_FAULT_VAL[5:2]])))
    else $error("fault did not force programmed output");

endmodule // stroke_position_sequencer
`default_nettype wire

/* File: testbench/valve_transducer.sv */
`timescale 1ns/1ns
`default_nettype none
// behavioural valve plus position transducer: the cylinder integrates the drive value
module valve_transducer (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control from the bench
  input wire logic move_en,
  input wire logic [15:0] pos_init,
  // valve drive in, measured position out
  input wire logic signed [15:0] drive_value,
  output logic [15:0] sensor_pos
);
  int p;
  // next position before clamping to the stroke ends
  assign p = int'(sensor_pos) + (int'(drive_value) >>> 10);
  // frozen position keeps law expectations exact; moving mode closes the loop
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sensor_pos <= pos_init;
    else if (move_en)
      sensor_pos <= (p < 0) ? 16'h0000 : (p > 65535) ? 16'hffff : 16'(p); // saturate at ends
  end
endmodule // valve_transducer
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  import stroke_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, enable_in = 1'b0, start_in = 1'b0;
  logic jog_up_in = 1'b0, jog_down_in = 1'b0, sensor_fault = 1'b0, wr = 1'b0, rd = 1'b0;
  logic move_en = 1'b0, ce = 1'b1;
  logic [15:0] cmd_pos = 16'h8000, cmd_speed = 16'h0000, sensor_pos;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic signed [15:0] drive_value;
  logic ready, in_position;
  int errors = 0, tests_run = 0;
  logic [15:0] rst_tab [12] = '{16'h0001, 16'h1000, 16'h0040, 16'h1000, 16'h0200,
    16'h0000, 16'h0003, 16'h0000, 16'h0000, 16'h0800, 16'h0000, 16'h0800};
  // law cases: curve, brake, deadband min, error
  int cases [6][4] = '{'{0, 4096, 0, 1024}, '{1, 4096, 0, 1024}, '{2, 4096, 0, 1024},
    '{0, 2048, 0, 1024}, '{0, 4096, 256, 64}, '{3, 4096, 0, -4096}};
  ////////////////////////////////////////////////////////////////////////////////
  stroke_position_sequencer #(.TICK_CYCLES(8)) u_dut (.clk(clk), .arst_n(arst_n), .ce(ce),
    .enable_in(enable_in), .start_in(start_in), .jog_up_in(jog_up_in),
    .jog_down_in(jog_down_in), .sensor_pos(sensor_pos), .cmd_pos(cmd_pos),
    .cmd_speed(cmd_speed), .sensor_fault(sensor_fault), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .drive_value(drive_value), .ready(ready),
    .in_position(in_position));
  valve_transducer u_valve (.clk(clk), .arst_n(arst_n), .move_en(move_en),
    .pos_init(16'h8000), .drive_value(drive_value), .sensor_pos(sensor_pos));
  ////////////////////////////////////////////////////////////////////////////////
  // clock and watchdog; the full run needs about a thousand cycles
  initial
  begin
    forever #20 clk = ~clk;
  end
  initial
  begin
    #(40 * 20000);
    errors++;
    finish_test();
  end
  // one-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= {16'h0000, v};
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  // pin sync plus two full sample periods
  task automatic settle();
    repeat (20) @(posedge clk);
    #1;
  endtask
  task automatic chk_state(input logic [2:0] s);
    rd_reg(OFS_STATUS, d);
    `CHK(d[6:4], s)
  endtask
  // expected drive from the documented law
  function automatic logic signed [15:0] law(input int e, b, f, mn);
    int m, u0, fq, u1;
    m = (e < 0) ? -e : e;
    if (m > b) m = b;
    u0 = m * 32767 / b;
    fq = f * 16 - (f - 1) * 16 * m / b;
    u1 = (u0 * fq) >>> 4;
    if (u1 > 32767) u1 = 32767;
    u1 = (u1 <= 1024) ? u1 * (1024 + mn) / 1024 : u1 + mn;
    if (u1 > 32767) u1 = 32767;
    return (e < 0) ? 16'(-u1) : 16'(u1);
  endfunction
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    `CHK(drive_value, 16'sh0000)
    `CHK(ready, 1'b0)
    // reset values, refused accesses
    for (int i = 0; i < 12; i++)
    begin
      rd_reg(8'(i * 4), d);
      `CHK(d, {16'h0000, rst_tab[i]})
    end
    rd_reg(8'h3c, d);
    `CHK(d, 32'h0)
    wr_reg(OFS_STATUS, 16'hffff);
    wr_reg(8'h05, 16'h0123);
    rd_reg(OFS_STATUS, d);
    `CHK(d, 32'h0)
    rd_reg(OFS_BRAKE, d);
    `CHK(d, 32'h1000)
    // read data stand for one cycle only
    @(posedge clk);
    #1;
    `CHK(rdata, 32'h0)
    // enable: hold at measured position
    cmd_pos <= 16'h1234;
    enable_in <= 1'b1;
    settle();
    `CHK(ready, 1'b1)
    chk_state(3'd1);
    rd_reg(OFS_TARGET, d);
    `CHK(d[15:0], 16'h8000)
    // law table while running
    start_in <= 1'b1;
    foreach (cases[i])
    begin
      wr_reg(OFS_CTRL, 16'(cases[i][0]));
      wr_reg(OFS_BRAKE, 16'(cases[i][1]));
      wr_reg(OFS_DB_MIN, 16'(cases[i][2]));
      cmd_pos <= 16'(32768 + cases[i][3]);
      settle();
      rd_reg(OFS_TARGET, d);
      `CHK(d[15:0], 16'(32768 + cases[i][3]))
      `CHK(drive_value, law(cases[i][3], cases[i][1],
        (cases[i][0] == 1) ? 3 : (cases[i][0] == 2) ? 5 : 1, cases[i][2]))
    end
    wr_reg(OFS_CTRL, 16'h0000);
    wr_reg(OFS_BRAKE, 16'h1000);
    wr_reg(OFS_DB_MIN, 16'h0000);
    // window boundary
    cmd_pos <= 16'h8040;
    settle();
    `CHK(in_position, 1'b1)
    cmd_pos <= 16'h8041;
    settle();
    `CHK(in_position, 1'b0)
    // external speed limit, jog refused while started
    wr_reg(OFS_CTRL, 16'h0004);
    cmd_speed <= 16'h0100;
    cmd_pos <= 16'h9000;
    jog_down_in <= 1'b1;
    settle();
    `CHK(drive_value, 16'sh0100)
    chk_state(3'd2);
    jog_down_in <= 1'b0;
    wr_reg(OFS_CTRL, 16'h0000);
    settle();
    // start removal stops one stopping distance ahead
    start_in <= 1'b0;
    settle();
    chk_state(3'd1);
    rd_reg(OFS_TARGET, d);
    `CHK(d[15:0], 16'h8200)
    // jog both ways; command ignored
    jog_up_in <= 1'b1;
    cmd_pos <= 16'h0000;
    settle();
    chk_state(3'd3);
    `CHK(drive_value, 16'sh1000)
    jog_up_in <= 1'b0;
    settle();
    chk_state(3'd1);
    rd_reg(OFS_TARGET, d);
    `CHK(d[15:0], 16'h8000)
    jog_down_in <= 1'b1;
    settle();
    `CHK(drive_value, -16'sh1000)
    jog_down_in <= 1'b0;
    settle();
    // clock enable low freezes syncs and ticks: a jog pin must not act
    ce <= 1'b0;
    jog_up_in <= 1'b1;
    settle();
    `CHK(drive_value, 16'sh0000)
    jog_up_in <= 1'b0;
    ce <= 1'b1;
    settle();
    // forced stroke in both directions over the whole area
    wr_reg(OFS_FORCE_HI, 16'hffff);
    wr_reg(OFS_CTRL, 16'h0018);
    settle();
    `CHK(drive_value, 16'sh0800)
    wr_reg(OFS_CTRL, 16'h0008);
    settle();
    `CHK(drive_value, -16'sh0800)
    // outside the working area the law holds the target again
    wr_reg(OFS_FORCE_LO, 16'h9000);
    settle();
    `CHK(drive_value, 16'sh0000)
    wr_reg(OFS_CTRL, 16'h0000);
    // fault events: deselected, selected, latched, cleared by enable
    wr_reg(OFS_FAULT_VAL, 16'h1234);
    wr_reg(OFS_FAULT_SEL, 16'h0000);
    sensor_fault <= 1'b1;
    settle();
    chk_state(3'd1);
    wr_reg(OFS_FAULT_SEL, 16'h0001);
    settle();
    chk_state(3'd4);
    `CHK(drive_value, 16'sh1234)
    `CHK(ready, 1'b0)
    sensor_fault <= 1'b0;
    settle();
    chk_state(3'd4);
    enable_in <= 1'b0;
    settle();
    `CHK(drive_value, 16'sh0000)
    enable_in <= 1'b1;
    settle();
    chk_state(3'd1);
    `CHK(ready, 1'b1)
    wr_reg(OFS_FAULT_SEL, 16'h0002);
    enable_in <= 1'b0;
    settle();
    `CHK(drive_value, 16'sh1234)
    // fault response as a run toward either end at the fault velocity
    wr_reg(OFS_CTRL, 16'h0060);
    settle();
    `CHK(drive_value, 16'sh0800)
    wr_reg(OFS_CTRL, 16'h0020);
    settle();
    `CHK(drive_value, -16'sh0800)
    wr_reg(OFS_CTRL, 16'h0000);
    // closed loop with a moving cylinder
    enable_in <= 1'b1;
    settle();
    cmd_pos <= 16'h9000;
    start_in <= 1'b1;
    move_en <= 1'b1;
    repeat (300) @(posedge clk);
    #1;
    `CHK(sensor_pos > 16'h8400, 1'b1)
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
